//--- rtl/frs_pkg.sv
// constants for the frequency slope protection stage
// assumes one frequency sample every SAMPLE_MS, 1 mHz per lsb
// Contract
// - pick-up happens only after the slope stays above the setting for 80 ms in a row.
// - start rises 60 ms after pick-up.
// - trip needs the average slope since pick-up to exceed the setting when the delay ends.
// - a picked-up stage releases after about 80 ms of stable frequency once the delay expired or the stage has tripped.
// - while picked up, slope wobble does not release; averaging runs from pick-up.
// - slope settings below 0.7 Hz/s get an extra floor on the operate time.
// - a minimum delay below the operate delay gives inverse time.
// - inverse trip time is setting times operate delay over the average slope.
// - trip never comes before the minimum delay.
// - four setting groups, chosen by digital input, virtual input or manual choice.
// - elapsed delay is kept as a percentage of operate time, 100 meaning trip.
// - each fault keeps its peak slope relative to the slope setting.
// - start and trip occurrences are counted for software.
package frs_pkg;
	// ---------------------------------------------------------------
	// timing, counted in samples
	// ---------------------------------------------------------------
	localparam int SAMPLE_MS = 10;
	localparam int PICKUP_MS = 80;
	localparam int START_MS = 60;
	localparam int STABLE_MS = 80;
	localparam int LOW_SLOPE_MINIMUM_DELAY_MS = 300;
	localparam logic [3:0] PICKUP_SAMPLES = 4'(PICKUP_MS / SAMPLE_MS);
	localparam logic [10:0] START_SAMPLES = 11'(START_MS / SAMPLE_MS);
	localparam logic [3:0] STABLE_SAMPLES = 4'(STABLE_MS / SAMPLE_MS);
	localparam logic [9:0] LOW_SLOPE_MINIMUM_DELAY =
		10'(LOW_SLOPE_MINIMUM_DELAY_MS / SAMPLE_MS);
	// ---------------------------------------------------------------
	// settings: slope in 0.1 Hz/s, times in samples
	// ---------------------------------------------------------------
	localparam logic [7:0] LOW_SLOPE_SET = 8'h07;
	localparam logic [7:0] SLOPE_RST = 8'h32;
	localparam logic [9:0] TOP_RST = 10'h032;
	localparam logic [9:0] MINIMUM_DELAY_RST = 10'h032;
	localparam logic [1:0] GROUP_RST = 2'h0;
	localparam int NUM_GROUPS = 4;
	localparam logic [19:0] PCT_FULL = 20'h00064;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_PICKED = 1'b1
	} frs_state_t;
endpackage : frs_pkg

//--- rtl/frs_stage.sv
// frequency slope protection stage: pick-up, start, trip, records
// assumes freqIn arrives with a one-cycle sampleValid at a fixed rate
`timescale 1ns/1ns
`default_nettype none
module frs_stage
	import frs_pkg::*;
(
	input wire logic clk, // 125 MHz
	input wire logic rstn, // sync reset
	input wire logic sampleValid, // new frequency sample
	input wire logic [15:0] freqIn, // frequency, 1 mHz lsb
	input wire logic cfgWrite, // write one setting group
	input wire logic [1:0] cfgGroup, // group written
	input wire logic [7:0] cfgSlope, // slope setting, 0.1 Hz/s
	input wire logic [9:0] cfgTOp, // operate delay, samples
	input wire logic [9:0] cfgTMin, // minimum delay, samples
	input wire logic grpDigValid, // digital group select active
	input wire logic [1:0] grpDig, // digital group choice
	input wire logic grpVirtValid, // virtual group select active
	input wire logic [1:0] grpVirt, // virtual group choice
	input wire logic grpManValid, // manual group select
	input wire logic [1:0] grpMan, // manual group choice
	input wire logic startCntClr, // clear start counter
	input wire logic tripCntClr, // clear trip counter
	input wire logic startOnEvDis, // 1 disables start-on event
	input wire logic startOffEvDis, // 1 disables start-off event
	input wire logic tripOnEvDis, // 1 disables trip-on event
	input wire logic tripOffEvDis, // 1 disables trip-off event
	output logic startOut, // start signal
	output logic tripOut, // trip signal
	output logic evStartOn, // start rise event
	output logic evStartOff, // start fall event
	output logic evTripOn, // trip rise event
	output logic evTripOff, // trip fall event
	output logic [15:0] startCounter, // start occurrences
	output logic [15:0] tripCounter, // trip occurrences
	output logic [15:0] faultSlopePct, // peak slope, % of setting
	output logic [15:0] elapsedDelayPercent, // elapsed % of delay
	output logic [15:0] slopeNow, // |df| per sample
	output logic [1:0] activeGroup // group in use
);
	// ---------------------------------------------------------------
	// divider for the percentage records
	// ---------------------------------------------------------------
	function automatic logic [15:0] pctDiv(input logic [19:0] num,
		input logic [15:0] den);
		logic [20:0] rem;
		logic [19:0] quo;
		rem = '0;
		quo = '0;
		for (int i = 19; i >= 0; i--) begin
			rem = {rem[19:0], num[i]};
			if (rem >= {5'h00, den}) begin
				rem = rem - {5'h00, den};
				quo[i] = 1'b1;
			end
		end
		return (quo[19:16] != 4'h0) ? 16'hffff : quo[15:0];
	endfunction : pctDiv

	// ---------------------------------------------------------------
	// setting groups
	// ---------------------------------------------------------------
	logic [7:0] slopeSet_q [NUM_GROUPS];
	logic [9:0] tOp_q [NUM_GROUPS];
	logic [9:0] minimum_delay_q [NUM_GROUPS];
	logic [1:0] group_q, group_d;

	for (genvar g = 0; g < NUM_GROUPS; g++) begin : gGroup
		always_ff @(posedge clk) begin
			if (!rstn) begin
				slopeSet_q[g] <= SLOPE_RST;
				tOp_q[g] <= TOP_RST;
				minimum_delay_q[g] <= MINIMUM_DELAY_RST;
			end else if (cfgWrite && cfgGroup == 2'(g)) begin
				slopeSet_q[g] <= cfgSlope;
				tOp_q[g] <= cfgTOp;
				minimum_delay_q[g] <= cfgTMin;
			end
		end
	end

	// digital input outranks virtual, virtual outranks manual
	assign group_d = grpDigValid ? grpDig :
		grpVirtValid ? grpVirt : grpManValid ? grpMan : group_q;

	wire [7:0] slopeSet = slopeSet_q[group_q];
	wire [9:0] tOp = tOp_q[group_q];
	wire [9:0] tMinSet = minimum_delay_q[group_q];
	// low settings are noisy, so the operate time gets a floor
	wire lowSlope = slopeSet < LOW_SLOPE_SET;
	wire [9:0] tMinEff = (lowSlope && tMinSet < LOW_SLOPE_MINIMUM_DELAY) ?
		LOW_SLOPE_MINIMUM_DELAY : tMinSet;

	// ---------------------------------------------------------------
	// slope measurement
	// ---------------------------------------------------------------
	frs_state_t state_q, state_d;
	logic [15:0] prevFreq_q, pickFreq_q, maxSlope_q;
	logic havePrev_q;
	logic [3:0] overCnt_q, stableCnt_q;
	logic [10:0] n_q;
	logic start_q, trip_q;

	wire [15:0] diffAbs = (freqIn >= prevFreq_q) ?
		freqIn - prevFreq_q : prevFreq_q - freqIn;
	wire [15:0] devAbs = (freqIn >= pickFreq_q) ?
		freqIn - pickFreq_q : pickFreq_q - freqIn;
	wire overSet = havePrev_q && (diffAbs > {8'h00, slopeSet});
	wire sampleIdle = sampleValid && state_q == ST_IDLE;
	wire samplePick = sampleValid && state_q == ST_PICKED;
	wire [3:0] overNext = overSet ? overCnt_q + 4'h1 : 4'h0;
	wire pickupNow = sampleIdle && overNext == PICKUP_SAMPLES;
	wire [10:0] nNext = (n_q == 11'h7ff) ? n_q : n_q + 11'h001;
	wire [3:0] stableNext = overSet ? 4'h0 :
		(stableCnt_q == STABLE_SAMPLES ? stableCnt_q : stableCnt_q + 4'h1);

	// ---------------------------------------------------------------
	// trip and release decisions
	// ---------------------------------------------------------------
	// average slope dev/n beats the setting: dev > set*n; before the
	// operate delay the inverse law needs dev > set*tOp instead
	wire [10:0] tLaw = (nNext > {1'b0, tOp}) ? nNext : {1'b0, tOp};
	// widen both factors first so the product cannot wrap at 11 bits
	wire [18:0] limit = 19'(slopeSet) * 19'(tLaw);
	wire avgOver = {3'h0, devAbs} > limit;
	wire minMet = nNext >= {1'b0, tMinEff};
	wire tripNow = samplePick && !trip_q && minMet && avgOver;
	// slope wobble alone never drops the stage
	wire releaseNow = samplePick && stableNext == STABLE_SAMPLES &&
		(nNext >= {1'b0, tOp} || trip_q);
	wire startNow = samplePick && nNext >= START_SAMPLES;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (pickupNow)
					state_d = ST_PICKED;
			end
			ST_PICKED: begin
				if (releaseNow)
					state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	wire start_d = releaseNow ? 1'b0 : (start_q || startNow);
	wire trip_d = releaseNow ? 1'b0 : (trip_q || tripNow);
	wire [15:0] maxNext = (diffAbs > maxSlope_q) ? diffAbs : maxSlope_q;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
			group_q <= GROUP_RST;
			prevFreq_q <= 16'h0000;
			pickFreq_q <= 16'h0000;
			havePrev_q <= 1'b0;
			overCnt_q <= 4'h0;
			stableCnt_q <= 4'h0;
			n_q <= 11'h000;
			maxSlope_q <= 16'h0000;
			start_q <= 1'b0;
			trip_q <= 1'b0;
		end else begin
			state_q <= state_d;
			group_q <= group_d;
			start_q <= start_d;
			trip_q <= trip_d;
			if (sampleValid) begin
				prevFreq_q <= freqIn;
				havePrev_q <= 1'b1;
				overCnt_q <= (state_q == ST_IDLE && !pickupNow) ?
					overNext : 4'h0;
				stableCnt_q <= samplePick ? stableNext : 4'h0;
				n_q <= samplePick ? nNext : 11'h000;
				maxSlope_q <= samplePick ? maxNext :
					(pickupNow ? diffAbs : maxSlope_q);
			end
			if (pickupNow)
				pickFreq_q <= freqIn;
		end
	end

	// ---------------------------------------------------------------
	// counters, fault record, events
	// ---------------------------------------------------------------
	logic [15:0] startCnt_q, tripCnt_q, fltPct_q, elapsed_q, slope_q;
	logic evSOn_q, evSOff_q, evTOn_q, evTOff_q;
	wire startRise = start_d && !start_q;
	wire tripRise = trip_d && !trip_q;
	// record taken when the fault ends; a trip counts as full delay
	wire [19:0] nPct = 20'(n_q * PCT_FULL);
	wire [15:0] elapsedNow = trip_q ? 16'(PCT_FULL) :
		pctDiv(nPct, {6'h00, tOp});
	wire [15:0] fltNow = pctDiv(20'(maxNext * PCT_FULL),
		{8'h00, slopeSet});

	always_ff @(posedge clk) begin
		if (!rstn) begin
			startCnt_q <= 16'h0000;
			tripCnt_q <= 16'h0000;
			fltPct_q <= 16'h0000;
			elapsed_q <= 16'h0000;
			slope_q <= 16'h0000;
			evSOn_q <= 1'b0;
			evSOff_q <= 1'b0;
			evTOn_q <= 1'b0;
			evTOff_q <= 1'b0;
		end else begin
			// a new occurrence in the clearing cycle still counts
			if (startRise)
				startCnt_q <= startCntClr ? 16'h0001 :
					startCnt_q + 16'h0001;
			else if (startCntClr)
				startCnt_q <= 16'h0000;
			if (tripRise)
				tripCnt_q <= tripCntClr ? 16'h0001 :
					tripCnt_q + 16'h0001;
			else if (tripCntClr)
				tripCnt_q <= 16'h0000;
			if (releaseNow) begin
				fltPct_q <= fltNow;
				elapsed_q <= elapsedNow;
			end
			if (sampleValid)
				slope_q <= havePrev_q ? diffAbs : 16'h0000;
			evSOn_q <= startRise && !startOnEvDis;
			evSOff_q <= !start_d && start_q && !startOffEvDis;
			evTOn_q <= tripRise && !tripOnEvDis;
			evTOff_q <= !trip_d && trip_q && !tripOffEvDis;
		end
	end

	assign startOut = start_q;
	assign tripOut = trip_q;
	assign evStartOn = evSOn_q;
	assign evStartOff = evSOff_q;
	assign evTripOn = evTOn_q;
	assign evTripOff = evTOff_q;
	assign startCounter = startCnt_q;
	assign tripCounter = tripCnt_q;
	assign faultSlopePct = fltPct_q;
	assign elapsedDelayPercent = elapsed_q;
	assign slopeNow = slope_q;
	assign activeGroup = group_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	chk_pickup_wait: assert property (
		state_q == ST_IDLE ##1 state_q == ST_PICKED |->
		$past(overCnt_q) == PICKUP_SAMPLES - 4'h1)
		else $error("pick-up without full over-slope run");
	chk_start_delay: assert property (
		$rose(start_q) |-> n_q == START_SAMPLES)
		else $error("start not at pick-up plus start delay");
	chk_trip_average: assert property (
		$rose(trip_q) |-> $past(devAbs) > $past(slopeSet))
		else $error("trip without slope above setting");
	chk_trip_min: assert property (
		$rose(trip_q) |-> n_q >= {1'b0, $past(tMinEff)})
		else $error("trip before minimum delay");
	chk_hold_picked: assert property (
		state_q == ST_PICKED && !releaseNow |=> state_q == ST_PICKED)
		else $error("stage dropped without release");
	chk_release_stable: assert property (
		$fell(state_q) |-> $past(stableNext) == STABLE_SAMPLES)
		else $error("release without stable frequency");
	chk_start_count: assert property (
		$rose(start_q) && !$past(startCntClr) |->
		startCnt_q == $past(startCnt_q) + 16'h0001)
		else $error("start counter missed a start");
	chk_event_trip: assert property (
		$rose(trip_q) && !$past(tripOnEvDis) |-> evTOn_q)
		else $error("trip event missing");
	chk_group_dig: assert property (
		grpDigValid |=> group_q == $past(grpDig))
		else $error("digital group select ignored");

	cov_trip: cover property ($rose(trip_q));
	cov_release_no_trip: cover property (
		$fell(state_q) && !$past(trip_q));
	cov_inverse_trip: cover property ($rose(trip_q) && tMinSet < tOp);
endmodule : frs_stage
`default_nettype wire

//--- tb/frs_freq_front.sv
// front-end model: one frequency sample every four clocks
// assumes the bench changes step and run on the falling edge
`timescale 1ns/1ns
`default_nettype none
module frs_freq_front (
	input wire logic clk, // bench clock
	input wire logic run, // emit samples
	input wire logic signed [15:0] step, // change per sample
	output logic sampleValid, // sample strobe
	output logic [15:0] freqIn // sample value
);
	logic [15:0] freq = 16'hc350;
	logic [1:0] gap = 2'h0;
	initial begin
		sampleValid <= 1'b0;
		freqIn <= 16'hc350;
	end
	// fixed spacing; off-strobe the bus toggles so stale data never matches
	always @(negedge clk) begin
		gap <= gap + 2'h1;
		if (run && gap == 2'h3) begin
			sampleValid <= 1'b1;
			freqIn <= freq + step;
			freq <= freq + step;
		end else begin
			sampleValid <= 1'b0;
			freqIn <= ~freqIn;
		end
	end
endmodule : frs_freq_front
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the frequency slope stage
// assumes frs_freq_front feeds samples; a reference model runs beside
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import frs_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, run = 1'b1, cfgWrite = 1'b0;
	logic signed [15:0] step = 16'sh0000;
	logic [1:0] cfgGroup = 2'h0, grpDig = 2'h0, grpVirt = 2'h0, grpMan = 2'h0;
	logic [7:0] cfgSlope = 8'h00;
	logic [9:0] cfgTOp = 10'h000, cfgTMin = 10'h000;
	logic grpDigValid = 1'b0, grpVirtValid = 1'b0, grpManValid = 1'b0;
	logic startCntClr = 1'b0, tripCntClr = 1'b0, startOnEvDis = 1'b0;
	logic startOffEvDis = 1'b0, tripOnEvDis = 1'b0, tripOffEvDis = 1'b0;
	logic sampleValid, startOut, tripOut, evStartOn, evStartOff;
	logic evTripOn, evTripOff;
	logic [15:0] freqIn, startCounter, tripCounter, faultSlopePct;
	logic [15:0] elapsedDelayPercent, slopeNow;
	logic [1:0] activeGroup;
	int gS[4], gT[4], gM[4], prev, pk, pf, d, dv, n, ov, stb, tm;
	int sc, tc, fp, ed, sl, grp, bad_count, cmp_count;
	bit have, pick, eSt, eTr, oS, oT, sOn, sOff, tOn, tOff, chk;
	frs_freq_front frs_freq_front_inst (.clk, .run, .step, .sampleValid,
		.freqIn);
	frs_stage frs_stage_inst (.clk, .rstn, .sampleValid, .freqIn, .cfgWrite,
		.cfgGroup, .cfgSlope, .cfgTOp, .cfgTMin, .grpDigValid, .grpDig,
		.grpVirtValid, .grpVirt, .grpManValid, .grpMan, .startCntClr,
		.tripCntClr, .startOnEvDis, .startOffEvDis, .tripOnEvDis,
		.tripOffEvDis, .startOut, .tripOut, .evStartOn, .evStartOff,
		.evTripOn, .evTripOff, .startCounter, .tripCounter, .faultSlopePct,
		.elapsedDelayPercent, .slopeNow, .activeGroup);
	initial begin
		forever #4 clk = ~clk;
	end
	// low slope settings get a floor of 30 samples
	function automatic int minimum_delay_eff(input int s, input int m);
		return (s < 7 && m < 30) ? 30 : m;
	endfunction : minimum_delay_eff
	// ---------------------------------------------------------------
	// reference model, updated on the sampling edge
	// ---------------------------------------------------------------
	always @(posedge clk) begin
		{sOn, sOff, tOn, tOff} = 4'h0;
		if (!rstn) begin
			gS = '{4{50}};
			gT = '{4{50}};
			gM = '{4{50}};
			{have, pick, eSt, eTr, oS, oT} = 6'h00;
			{sc, tc, fp, ed, sl, ov, grp} = 0;
		end else begin
			if (startCntClr)
				sc = 0;
			if (tripCntClr)
				tc = 0;
			if (sampleValid) begin
				d = freqIn > prev ? freqIn - prev : prev - freqIn;
				if (have && !pick) begin
					ov = d > gS[grp] ? ov + 1 : 0;
					if (ov == 8) begin
						// peak tracked from the pick-up sample on
						pk = d;
						pick = 1;
						n = 0;
						pf = freqIn;
						stb = 0;
					end
				end else if (pick) begin
					n++;
					pk = d > pk ? d : pk;
					eSt = eSt || n == 6;
					tm = minimum_delay_eff(gS[grp], gM[grp]);
					dv = freqIn > pf ? freqIn - pf : pf - freqIn;
					if (n >= tm && dv > gS[grp] * (n > gT[grp] ? n : gT[grp]))
						eTr = 1;
					stb = d <= gS[grp] ? stb + 1 : 0;
					// release sees the trip state held before this sample
					if (stb >= 8 && (n >= gT[grp] || oT)) begin
						fp = pk * 100 / gS[grp];
						ed = oT ? 100 : (n - 1) * 100 / gT[grp];
						{pick, eSt, eTr, ov} = 0;
					end
				end
				if (have)
					sl = d;
				have = 1;
				prev = freqIn;
			end
			sc += eSt && !oS;
			tc += eTr && !oT;
			sOn = eSt && !oS && !startOnEvDis;
			sOff = !eSt && oS && !startOffEvDis;
			tOn = eTr && !oT && !tripOnEvDis;
			tOff = !eTr && oT && !tripOffEvDis;
			{oS, oT} = {eSt, eTr};
			if (cfgWrite) begin
				gS[cfgGroup] = cfgSlope;
				gT[cfgGroup] = cfgTOp;
				gM[cfgGroup] = cfgTMin;
			end
			grp = grpDigValid ? grpDig : grpVirtValid ? grpVirt :
				grpManValid ? grpMan : grp;
		end
	end
	task automatic cmp(input logic [15:0] got, input int exp, input string m);
		cmp_count++;
		if (got !== 16'(exp)) begin
			bad_count++;
			$display("CHECK FAILED %0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask : cmp
	always @(negedge clk) begin
		if (chk) begin
			cmp(startOut, eSt, "start");
			cmp(tripOut, eTr, "trip");
			cmp(evStartOn, sOn, "start on");
			cmp(evStartOff, sOff, "start off");
			cmp(evTripOn, tOn, "trip on");
			cmp(evTripOff, tOff, "trip off");
			cmp(startCounter, sc, "starts");
			cmp(tripCounter, tc, "trips");
			cmp(faultSlopePct, fp, "peak");
			cmp(elapsedDelayPercent, ed, "elapsed");
			cmp(slopeNow, sl, "slope");
			cmp(activeGroup, grp, "group");
		end
	end
	task automatic go(input int s, input int k);
		step = 16'(s);
		repeat (k) @(posedge clk iff sampleValid);
		@(negedge clk);
	endtask : go
	task automatic cfg(input int g, input int s, input int t, input int m);
		{cfgWrite, cfgGroup, cfgSlope} = {1'b1, 2'(g), 8'(s)};
		{cfgTOp, cfgTMin} = {10'(t), 10'(m)};
		@(negedge clk);
		cfgWrite = 1'b0;
	endtask : cfg
	task automatic ev_rand();
		{startOnEvDis, startOffEvDis, tripOnEvDis, tripOffEvDis} = 4'($urandom);
	endtask : ev_rand
	task automatic final_report();
		$display("mismatches %0d comparisons %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	initial begin
		#100000;
		bad_count++;
		$display("CHECK FAILED %0t watchdog expired", $time);
		final_report();
	end
	initial begin
		@(posedge clk);
		chk = 1;
	end
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(32'ha0ef));
		repeat (6) @(negedge clk);
		rstn = 1'b1;
		cfg(0, 10, 20, 20);
		go(0, 3);
		go(15, 7);
		go(0, 10);
		go(15, 30);
		go(0, 12);
		ev_rand();
		cfg(1, 10, 20, 5);
		{grpManValid, grpMan} = 3'h5;
		go(-40, 16);
		go(0, 12);
		ev_rand();
		cfg(2, 5, 20, 5);
		{grpVirtValid, grpVirt} = 3'h6;
		go(100, 40);
		go(0, 12);
		cfg(3, 10, 20, 20);
		{grpDigValid, grpDig} = 3'h7;
		go(15, 9);
		repeat (4) begin
			go(12, 1);
			go(-12, 1);
		end
		go(0, 12);
		{startCntClr, tripCntClr} = 2'h3;
		@(negedge clk);
		{startCntClr, tripCntClr} = 2'h0;
		repeat (4) begin
			ev_rand();
			grpDig = 2'($urandom);
			go(int'($urandom_range(30)) - 15, 10);
			go(0, 22);
		end
		go(15, 10);
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		go(0, 3);
		final_report();
	end
endmodule : testbench
`default_nettype wire
